// ---- src/sbp_fifo.sv ----
`timescale 1ns/100ps

module sbp_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
)
(
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_clk_en,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [W-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [W-1:0] o_out_data
);

    localparam int PW = $clog2(DEPTH);

    logic [W-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_ptr_q;
    logic [PW-1:0] rd_ptr_q;
    logic [PW:0] count_q;
    logic push;
    logic pop;

    // full only refuses when nothing leaves in the same cycle
    assign o_in_ready = (count_q != (PW+1)'(DEPTH)) || i_out_ready;
    assign o_out_valid = (count_q != '0);
    assign o_out_data = mem_q[rd_ptr_q];
    assign push = i_clk_en && i_in_valid && o_in_ready;
    assign pop = i_clk_en && o_out_valid && i_out_ready;

    // ========================================
    // storage
    always_ff @(posedge i_sys_clk)
    begin
        if (push)
        begin
            mem_q[wr_ptr_q] <= i_in_data;
        end
    end

    // ========================================
    // pointers
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_q <= PW'(wr_ptr_q + 1'b1);
            end
            if (pop)
            begin
                rd_ptr_q <= PW'(rd_ptr_q + 1'b1);
            end
            if (push && !pop)
            begin
                count_q <= (PW+1)'(count_q + 1'b1);
            end
            else if (pop && !push)
            begin
                count_q <= (PW+1)'(count_q - 1'b1);
            end
        end
    end

endmodule : sbp_fifo

// ---- src/sbp_pkg.sv ----
package sbp_pkg;

    // ========================================
    // sizes
    localparam int ADDR_W = 18;
    localparam int HI_W = 16;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int DATA_W = 36;
    localparam int MEM_WORDS = 262144;
    localparam int WQ_DEPTH = 16;

    // ========================================
    // timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int READ_LAT_NS = 50;
    localparam int READ_LAT_CYC = (READ_LAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ========================================
    // field positions and reset values
    localparam int LO_POS = 0;
    localparam int HI_POS = 2;
    localparam logic [1:0] CNT_RST = 2'h0;
    localparam logic [3:0] MASK_ALL = 4'hf;
    localparam logic [3:0] MASK_NONE = 4'h0;

    // ========================================
    // types
    typedef enum logic [1:0] {
        CYC_DESEL = 2'b00,
        CYC_READ = 2'b01,
        CYC_WRITE = 2'b10
    } sbp_cyc_t;

    typedef struct packed {
        logic [LANE_W-1:0] data_lane3;
        logic [LANE_W-1:0] data_lane2;
        logic [LANE_W-1:0] data_lane1;
        logic [LANE_W-1:0] data_lane0;
    } sbp_lanes_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        sbp_lanes_t data;
        logic [LANES-1:0] mask;
    } sbp_wr_t;

endpackage : sbp_pkg

// ---- src/sbp_sram_port.sv ----
// Operation
// - address inputs are captured at the rising clock edge; controller keeps them stable.
// - during burst and wait cycles low two address bits come from the counter.
// - address, data, enables, write and burst controls are registered together.
// - a low byte lane enable asks for a write, high asks for a read.
// - each of four byte lane enables governs the write of exactly its own data lane.
// - data pins float while any lane enable and the byte write gate are low.
// - byte write gate is active low; byte writes need it sampled low.
// - global write sampled low writes all 36 bits regardless of lane enables and the byte write gate.
// - primary chip enable is active low, selects and qualifies processor strobe.
// - expansion select is active high and must be high for selection.
// - third active-low select exists on one variant only; else it is ignored.
// - output enable acts asynchronously, active low; otherwise outputs float.
// - burst advance low steps the counter; high holds it as a wait cycle.
// - processor strobe with chip enable low loads an address and starts a read.
// - controller strobe loads an address and selects or deselects per enables.
// - controller strobe cycle writes if write controls ask, else reads.
// - burst order select low gives linear order, high gives interleaved.
// - snooze high puts the port into low power standby.
// - lane enables have no write effect while the byte write gate is high.
// - the data bus is four ordered lanes, each paired with its enable.
`timescale 1ns/100ps

module sbp_sram_port #(
    parameter bit THIRD_SELECT_EN = 1'b0
)
(
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_clk_en,
    input wire logic [sbp_pkg::HI_W-1:0] i_addr_hi,
    input wire logic i_addr_bit_one,
    input wire logic i_addr_bit_zero,
    input wire logic i_chip_en_n,
    input wire logic i_expansion_select_hi,
    input wire logic i_third_select_n,
    input wire logic i_proc_addr_strobe_n,
    input wire logic i_ctrl_addr_strobe_n,
    input wire logic i_burst_advance_n,
    input wire logic i_lane0_write_en_n,
    input wire logic i_lane1_write_en_n,
    input wire logic i_lane2_write_en_n,
    input wire logic i_lane3_write_en_n,
    input wire logic i_byte_write_gate_n,
    input wire logic i_global_write_n,
    input wire logic i_out_en_n,
    input wire logic i_burst_order,
    input wire logic i_snooze_req,
    input wire sbp_pkg::sbp_lanes_t i_data,
    output sbp_pkg::sbp_lanes_t o_data,
    output logic [sbp_pkg::LANES-1:0] o_data_oe,
    output logic o_wr_ready,
    output logic o_snooze_active
);

    // ========================================
    // state
    logic sel_q;
    logic order_q;
    logic [1:0] load_lo_q;
    logic [1:0] cnt_q;
    logic [sbp_pkg::HI_W-1:0] hi_q;
    logic [sbp_pkg::ADDR_W-1:0] rd_addr_q;
    logic rd_pend_q;
    logic rd_valid_q;
    logic snooze_q;
    sbp_pkg::sbp_lanes_t rd_data_q;
    logic [sbp_pkg::DATA_W-1:0] mem_q [sbp_pkg::MEM_WORDS];

    // ========================================
    // decode of sampled inputs
    logic enables_ok;
    logic proc_start;
    logic ctrl_start;
    logic advance;
    logic [3:0] lane_wr_n;
    logic [3:0] byte_mask;
    logic [3:0] wr_mask;
    logic wr_req;
    logic bw_float;
    logic [1:0] cnt_d;
    logic [1:0] load_lo_d;
    logic [sbp_pkg::HI_W-1:0] hi_d;
    logic [1:0] burst_lo;
    logic sel_d;
    logic [sbp_pkg::ADDR_W-1:0] cur_addr;
    sbp_pkg::sbp_cyc_t cyc_kind;
    sbp_pkg::sbp_wr_t push_wr;
    sbp_pkg::sbp_wr_t pop_wr;
    logic pop_valid;
    logic pop_ready;

    assign lane_wr_n = {i_lane3_write_en_n, i_lane2_write_en_n,
                        i_lane1_write_en_n, i_lane0_write_en_n};

    assign enables_ok = !i_chip_en_n && i_expansion_select_hi
                        && (!THIRD_SELECT_EN || !i_third_select_n);

    // processor strobe only counts with chip enable low
    assign proc_start = !i_proc_addr_strobe_n && !i_chip_en_n
                        && !i_snooze_req;
    assign ctrl_start = !proc_start && !i_ctrl_addr_strobe_n
                        && !i_snooze_req;

    assign byte_mask = i_byte_write_gate_n ? sbp_pkg::MASK_NONE
                       : ~lane_wr_n;
    assign wr_mask = !i_global_write_n ? sbp_pkg::MASK_ALL : byte_mask;
    assign wr_req = |wr_mask;

    assign advance = !i_burst_advance_n && !proc_start && !ctrl_start
                     && sel_q && !i_snooze_req;

    // ========================================
    // next burst address
    always_comb
    begin
        cnt_d = cnt_q;
        load_lo_d = load_lo_q;
        hi_d = hi_q;
        sel_d = sel_q;
        if (proc_start || ctrl_start)
        begin
            cnt_d = sbp_pkg::CNT_RST;
            load_lo_d = {i_addr_bit_one, i_addr_bit_zero};
            hi_d = i_addr_hi;
            sel_d = enables_ok;
        end
        else if (advance)
        begin
            cnt_d = 2'(cnt_q + 2'h1);
        end
    end

    // counter supplies the low bits in burst and wait cycles
    assign burst_lo = order_q ? (load_lo_d ^ cnt_d)
                      : 2'(load_lo_d + cnt_d);
    assign cur_addr = {hi_d, burst_lo};

    always_comb
    begin
        if (!sel_d || i_snooze_req)
        begin
            cyc_kind = sbp_pkg::CYC_DESEL;
        end
        else if (proc_start)
        begin
            cyc_kind = sbp_pkg::CYC_READ;
        end
        else if (wr_req)
        begin
            cyc_kind = sbp_pkg::CYC_WRITE;
        end
        else
        begin
            cyc_kind = sbp_pkg::CYC_READ;
        end
    end

    // ========================================
    // address and control registers
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn)
        begin
            sel_q <= 1'b0;
            cnt_q <= sbp_pkg::CNT_RST;
            load_lo_q <= 2'h0;
            hi_q <= '0;
        end
        else if (i_clk_en)
        begin
            sel_q <= sel_d;
            cnt_q <= cnt_d;
            load_lo_q <= load_lo_d;
            hi_q <= hi_d;
        end
    end

    // static order select, resampled every edge with i_clk_en high
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn)
        begin
            order_q <= 1'b1;
            snooze_q <= 1'b0;
        end
        else if (i_clk_en)
        begin
            order_q <= i_burst_order;
            snooze_q <= i_snooze_req;
        end
    end

    // ========================================
    // pipelined read path
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn)
        begin
            rd_addr_q <= '0;
            rd_pend_q <= 1'b0;
            rd_valid_q <= 1'b0;
        end
        else if (i_clk_en)
        begin
            rd_addr_q <= cur_addr;
            rd_pend_q <= (cyc_kind == sbp_pkg::CYC_READ);
            rd_valid_q <= rd_pend_q;
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_clk_en && rd_pend_q)
        begin
            rd_data_q <= mem_q[rd_addr_q];
        end
    end

    // ========================================
    // self-timed writes through the queue
    assign push_wr.addr = cur_addr;
    assign push_wr.data = i_data;
    assign push_wr.mask = wr_mask;
    // standby stops the array side from draining
    assign pop_ready = !i_snooze_req;

    sbp_fifo #(
        .W($bits(sbp_pkg::sbp_wr_t)),
        .DEPTH(sbp_pkg::WQ_DEPTH)
    ) u_wq (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_clk_en(i_clk_en),
        .i_in_valid(cyc_kind == sbp_pkg::CYC_WRITE),
        .o_in_ready(o_wr_ready),
        .i_in_data(push_wr),
        .o_out_valid(pop_valid),
        .i_out_ready(pop_ready),
        .o_out_data(pop_wr)
    );

    always_ff @(posedge i_sys_clk)
    begin
        if (i_clk_en && pop_valid && pop_ready)
        begin
            for (int l = 0; l < sbp_pkg::LANES; l++)
            begin
                if (pop_wr.mask[l])
                begin
                    mem_q[pop_wr.addr][l*sbp_pkg::LANE_W +: sbp_pkg::LANE_W]
                        <= pop_wr.data[l*sbp_pkg::LANE_W +: sbp_pkg::LANE_W];
                end
            end
        end
    end

    // ========================================
    // output drivers
    assign bw_float = !i_byte_write_gate_n && !(&lane_wr_n);
    assign o_data_oe = {sbp_pkg::LANES{rd_valid_q && !i_out_en_n
                       && !bw_float && !i_snooze_req}};
    assign o_data = rd_data_q;
    assign o_snooze_active = snooze_q;

    // ========================================
    // assertions
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rstn);

    a_proc_addr_strobe_n_gated: assert property (
        i_clk_en && i_chip_en_n && i_ctrl_addr_strobe_n && i_burst_advance_n
        |=> sel_q == $past(sel_q) && cnt_q == $past(cnt_q))
        else $error("processor strobe acted without chip enable");

    a_read_latency: assert property (
        (i_clk_en && proc_start && enables_ok) ##1 i_clk_en
        |=> rd_valid_q)
        else $error("read data not valid one edge after address");

    a_wait_hold: assert property (
        i_clk_en && !proc_start && !ctrl_start && i_burst_advance_n
        |=> cnt_q == $past(cnt_q))
        else $error("counter moved in a wait cycle");

    a_adv_step: assert property (
        i_clk_en && advance |=> cnt_q == 2'($past(cnt_q) + 2'h1))
        else $error("counter did not step on advance");

    a_linear_seq: assert property (
        (i_clk_en && (proc_start || ctrl_start) && !order_q && !i_burst_order)
        ##1 (i_clk_en && advance && !i_burst_order && cnt_q == 2'h0)
        |=> rd_addr_q[1:0] == 2'($past(rd_addr_q[1:0]) + 2'h1))
        else $error("linear burst order wrong");

    a_inter_seq: assert property (
        (i_clk_en && (proc_start || ctrl_start) && order_q && i_burst_order)
        ##1 (i_clk_en && advance && i_burst_order && cnt_q == 2'h0)
        |=> rd_addr_q[1:0] == ($past(rd_addr_q[1:0]) ^ 2'h1))
        else $error("interleaved burst order wrong");

    a_gate_high: assert property (
        i_byte_write_gate_n && i_global_write_n
        |-> cyc_kind != sbp_pkg::CYC_WRITE)
        else $error("write without gate or global write");

    a_global_all: assert property (
        !i_global_write_n && cyc_kind == sbp_pkg::CYC_WRITE
        |-> push_wr.mask == sbp_pkg::MASK_ALL)
        else $error("global write did not cover all lanes");

    a_lane_map: assert property (
        i_global_write_n && cyc_kind == sbp_pkg::CYC_WRITE
        |-> push_wr.mask == ~lane_wr_n)
        else $error("lane enable mapped to wrong lane");

    a_bw_float: assert property (
        !i_byte_write_gate_n && !(&lane_wr_n) |-> o_data_oe == 4'h0)
        else $error("data driven during byte write");

    a_oe_float: assert property (
        i_out_en_n |-> o_data_oe == 4'h0)
        else $error("data driven with output enable high");

    a_deselect: assert property (
        i_clk_en && ctrl_start && !i_expansion_select_hi |=> !sel_q)
        else $error("not deselected by controller strobe");

    a_snooze_idle: assert property (
        i_snooze_req |-> cyc_kind == sbp_pkg::CYC_DESEL)
        else $error("cycle started in standby");

    c_burst_four: cover property (
        (i_clk_en && proc_start && enables_ok)
        ##1 (i_clk_en && advance) [*3]);

    c_ctrl_write: cover property (
        i_clk_en && ctrl_start && cyc_kind == sbp_pkg::CYC_WRITE);

    c_wait_cycle: cover property (
        i_clk_en && sel_q && !proc_start && !ctrl_start && i_burst_advance_n);

    c_queue_full: cover property (!o_wr_ready);

endmodule : sbp_sram_port

// ---- tb/sbp_ctrl_model.sv ----
`timescale 1ns/100ps

module sbp_ctrl_model
(
    input wire logic i_sys_clk,
    output logic [sbp_pkg::HI_W-1:0] o_addr_hi,
    output logic o_addr_bit_one,
    output logic o_addr_bit_zero,
    output logic o_chip_en_n,
    output logic o_expansion_select_hi,
    output logic o_proc_addr_strobe_n,
    output logic o_ctrl_addr_strobe_n,
    output logic o_burst_advance_n,
    output logic [3:0] o_lane_n,
    output logic o_byte_write_gate_n,
    output logic o_global_write_n,
    output sbp_pkg::sbp_lanes_t o_data
);
    // ========================================
    // idle bus at time zero
    initial
    begin
        {o_proc_addr_strobe_n, o_ctrl_addr_strobe_n, o_burst_advance_n} = 3'h7;
        {o_chip_en_n, o_expansion_select_hi, o_byte_write_gate_n, o_global_write_n} = 4'hb;
        o_lane_n = 4'hf;
        {o_addr_hi, o_addr_bit_one, o_addr_bit_zero} = 18'h00000;
        o_data = 36'h000000000;
    end

    // ========================================
    // one bus cycle: drive after falling edge, hold across the rising edge
    task automatic cyc(input logic ps_n, input logic cs_n, input logic ce_n, input logic sel,
        input logic adv_n, input logic gw_n, input logic gate_n, input logic [3:0] ln,
        input logic [17:0] a, input sbp_pkg::sbp_lanes_t d, input logic drv);
        {o_addr_hi, o_addr_bit_one, o_addr_bit_zero} = a;
        {o_proc_addr_strobe_n, o_ctrl_addr_strobe_n, o_burst_advance_n} = {ps_n, cs_n, adv_n};
        {o_chip_en_n, o_expansion_select_hi} = {ce_n, sel};
        {o_global_write_n, o_byte_write_gate_n, o_lane_n} = {gw_n, gate_n, ln};
        // released data lines show the inverse of the last value
        o_data = drv ? d : ~o_data;
        @(posedge i_sys_clk);
        @(negedge i_sys_clk);
    endtask : cyc
endmodule : sbp_ctrl_model

// ---- tb/sbp_sram_port_test.sv ----
`timescale 1ns/100ps

module sbp_sram_port_test;
    localparam logic [17:0] BASE = 18'h12340;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic out_en_n = 1'b0;
    logic order = 1'b1;
    logic snooze = 1'b0;
    logic [sbp_pkg::HI_W-1:0] a_hi;
    logic a1, a0, ce_n, sel, ps_n, cs_n, adv_n, gate_n, gw_n, wr_ready, snz;
    logic [3:0] ln;
    logic [3:0] oe;
    sbp_pkg::sbp_lanes_t di, dq;
    logic third_n = 1'b0;
    int errors = 0;
    int samples_checked = 0;

    always #25 clk = ~clk;

    sbp_ctrl_model u_sbp_ctrl_model (.i_sys_clk(clk), .o_addr_hi(a_hi),
        .o_addr_bit_one(a1), .o_addr_bit_zero(a0), .o_chip_en_n(ce_n),
        .o_expansion_select_hi(sel), .o_proc_addr_strobe_n(ps_n),
        .o_ctrl_addr_strobe_n(cs_n), .o_burst_advance_n(adv_n), .o_lane_n(ln),
        .o_byte_write_gate_n(gate_n), .o_global_write_n(gw_n), .o_data(di));

    sbp_sram_port u_sbp_sram_port (.i_sys_clk(clk), .i_rstn(rstn), .i_clk_en(1'b1),
        .i_addr_hi(a_hi), .i_addr_bit_one(a1), .i_addr_bit_zero(a0), .i_chip_en_n(ce_n),
        .i_expansion_select_hi(sel), .i_third_select_n(third_n), .i_proc_addr_strobe_n(ps_n),
        .i_ctrl_addr_strobe_n(cs_n), .i_burst_advance_n(adv_n), .i_lane0_write_en_n(ln[0]),
        .i_lane1_write_en_n(ln[1]), .i_lane2_write_en_n(ln[2]), .i_lane3_write_en_n(ln[3]),
        .i_byte_write_gate_n(gate_n), .i_global_write_n(gw_n), .i_out_en_n(out_en_n),
        .i_burst_order(order), .i_snooze_req(snooze), .i_data(di), .o_data(dq),
        .o_data_oe(oe), .o_wr_ready(wr_ready), .o_snooze_active(snz));

    // ========================================
    // helpers
    function automatic logic [35:0] pat(input int i);
        pat = {9'h1a5 ^ 9'(i), 9'(i * 3), 9'h0f0 + 9'(i), 9'h111 ^ 9'(i * 7)};
    endfunction : pat

    task automatic chk(input string nm, input logic [35:0] exp, input logic [35:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
            errors++;
        end
    endtask : chk

    task automatic rd(input logic [17:0] a);
        u_sbp_ctrl_model.cyc(0, 1, 0, 1, 1, 1, 1, 4'hf, a, '0, 0);
    endtask : rd

    task automatic step(input logic burst_advance_n);
        u_sbp_ctrl_model.cyc(1, 1, 0, 1, burst_advance_n, 1, 1, 4'hf, '0, '0, 0);
    endtask : step

    task automatic desel();
        u_sbp_ctrl_model.cyc(1, 0, 0, 0, 1, 1, 1, 4'hf, '0, '0, 0);
    endtask : desel

    task automatic wr(input logic [17:0] a, input logic [35:0] d, input logic gw,
        input logic gate, input logic [3:0] lanes);
        u_sbp_ctrl_model.cyc(1, 0, 0, 1, 1, gw, gate, lanes, a, d, 1);
    endtask : wr

    task automatic summarize();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize

    // ========================================
    // scenarios
    task automatic t_burst(input logic ord);
        int idx[5] = '{0, 1, 2, 2, 3};
        logic [1:0] lo;
        order = ord;
        desel();
        rd(BASE + 18'h1);
        for (int s = 0; s < 5; s++)
        begin
            if (s < 4)
                step(s == 2);
            else
                desel();
            lo = ord ? (2'h1 ^ 2'(idx[s])) : (2'h1 + 2'(idx[s]));
            chk("burst data", pat(lo), dq);
        end
    endtask : t_burst

    task automatic t_oe();
        rd(BASE);
        desel();
        chk("oe driven", 36'(4'hf), 36'(oe));
        chk("read data", pat(0), dq);
        out_en_n = 1'b1;
        #1;
        chk("oe floated", 36'(4'h0), 36'(oe));
        out_en_n = 1'b0;
    endtask : t_oe

    task automatic t_bytes();
        logic [35:0] exp;
        exp = pat(2);
        for (int l = 0; l < 4; l++)
        begin
            rd(BASE + 18'h2);
            wr(BASE + 18'h2, pat(l + 8), 1, 0, ~(4'h1 << l));
            chk("oe on byte write", 36'(4'h0), 36'(oe));
            exp[l * 9 +: 9] = pat(l + 8) >> (l * 9);
            desel();
            rd(BASE + 18'h2);
            desel();
            chk("lane write", exp, dq);
        end
        wr(BASE + 18'h2, pat(20), 1, 1, 4'h0);
        desel();
        chk("gate high read", exp, dq);
        chk("gate high oe", 36'(4'hf), 36'(oe));
    endtask : t_bytes

    task automatic t_ignore();
        order = 1'b0;
        rd(BASE);
        u_sbp_ctrl_model.cyc(0, 1, 1, 1, 0, 1, 1, 4'hf, BASE + 18'h3, '0, 0);
        u_sbp_ctrl_model.cyc(0, 1, 1, 1, 1, 1, 1, 4'hf, BASE + 18'h3, '0, 0);
        chk("ignored strobe", pat(1), dq);
        desel();
        chk("advance kept", pat(1), dq);
        u_sbp_ctrl_model.cyc(1, 0, 0, 0, 1, 1, 1, 4'hf, BASE, '0, 0);
        desel();
        chk("deselected oe", 36'(4'h0), 36'(oe));
    endtask : t_ignore

    task automatic t_snooze();
        snooze = 1'b1;
        rd(BASE);
        desel();
        chk("snooze flag", 36'h1, 36'(snz));
        chk("snooze oe", 36'(4'h0), 36'(oe));
        snooze = 1'b0;
        desel();
        chk("snooze off", 36'h0, 36'(snz));
    endtask : t_snooze

    // back-to-back writes through the queue, then back-to-back reads
    task automatic t_queue();
        logic [17:0] qa;
        qa = BASE + 18'h10;
        for (int i = 0; i < 16; i++)
        begin
            wr(qa + 18'(i), pat(i + 32), 0, 1, 4'hf);
            chk("queue ready", 36'h1, 36'(wr_ready));
        end
        desel();
        chk("queue drained", 36'h1, 36'(wr_ready));
        for (int i = 0; i < 17; i++)
        begin
            if (i < 16)
                rd(qa + 18'(i));
            else
                desel();
            if (i > 0)
            begin
                chk("queue order", pat(i + 31), dq);
                chk("back to back oe", 36'(4'hf), 36'(oe));
            end
        end
    endtask : t_queue

    // ========================================
    // main sequence and watchdog
    initial
    begin
        repeat (6) @(negedge clk);
        rstn = 1'b1;
        for (int i = 0; i < 4; i++)
            wr(BASE + 18'(i), pat(i), 0, 1, 4'hf);
        desel();
        desel();
        t_burst(1'b0);
        t_burst(1'b1);
        t_oe();
        t_bytes();
        t_ignore();
        t_snooze();
        t_queue();
        summarize();
    end

    initial
    begin
        #(5000 * 50);
        errors++;
        summarize();
    end
endmodule : sbp_sram_port_test
